// >>> backplane_model.sv
`timescale 1ns/1ps
module backplane_model
(
    input wire logic clock,
    input wire logic start,
    input wire logic [7:0] burst,
    output logic bp_clock,
    output logic [7:0] bp_data,
    output logic busy
);
    logic [7:0] sent;
    // counting bytes, clock still between bursts
    initial
    begin
        bp_clock = 1'b0;
        bp_data = 8'hff;
        busy = 1'b0;
        sent = 8'h00;
        forever
        begin
            @(posedge clock);
            if (start)
            begin
                busy = 1'b1;
                repeat (burst)
                begin
                    @(negedge clock);
                    bp_data = sent;
                    repeat (4) @(negedge clock);
                    bp_clock = 1'b1;
                    repeat (4) @(negedge clock);
                    bp_clock = 1'b0;
                    sent = sent + 8'h01;
                end
                repeat (4) @(negedge clock);
                bp_data = ~bp_data; // last byte inverted, not returned to 8'hff
                busy = 1'b0;
            end
        end
    end
endmodule // backplane_model

// >>> edge_sync.sv
`timescale 1ns/1ps
module edge_sync
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic async_in,
    output logic rise
);

    logic meta_reg;
    logic meta_next;
    logic stable_reg;
    logic stable_next;
    logic last_reg;
    logic last_next;
    logic rise_next;

    // two-stage synchroniser then edge detect on the second stage only
    always_comb
    begin
        meta_next = async_in;
        stable_next = meta_reg;
        last_next = stable_reg;
        rise_next = stable_reg & ~last_reg;
    end

    // registers
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_reg <= 1'b0;
            stable_reg <= 1'b0;
            last_reg <= 1'b0;
            rise <= 1'b0;
        end
        else
        begin
            meta_reg <= meta_next;
            stable_reg <= stable_next;
            last_reg <= last_next;
            rise <= rise_next;
        end
    end

endmodule // edge_sync

// >>> slip_pkg.sv
package slip_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] event_status_offset = 16'h0b08;
    localparam logic [7:0] event_status_reset = 8'h00;
    localparam int overflow_bit = 7;
    localparam int underflow_bit = 6;
    localparam int slip_bit = 5;

    // ------------------------------------------------------------
    // buffer geometry
    // ------------------------------------------------------------
    localparam int frame_bytes = 32;
    localparam int frames_held = 2;
    localparam int sync_stages = 2;

    // host access carrier
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
    } host_req_t;

    // sticky event flags
    typedef struct packed {
        logic overflow;
        logic underflow;
        logic slip;
    } slip_events_t;

endpackage

// >>> slip_properties.sv
`timescale 1ns/1ps
module slip_properties
(
    input wire logic clock,
    input wire logic reset_n,
    input wire slip_pkg::host_req_t host_req,
    input wire logic [7:0] host_rdata,
    input wire logic host_rvalid,
    input wire slip_pkg::slip_events_t events
);
    logic hit;
    // status read decode
    assign hit = host_req.rd
        && host_req.addr == slip_pkg::event_status_offset;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // ----------
    // status flags
    // ----------
    a_read_answered:
        assert property (host_req.rd |=> host_rvalid) else $error("no answer");
    a_idle_quiet:
        assert property (!host_rvalid |-> host_rdata == 8'h00)
        else $error("data without answer");
    a_flags_shown:
        assert property (hit |=> host_rdata == {$past(events), 5'h00})
        else $error("status mismatch");
    a_flags_sticky:
        assert property (!hit |=> ({events} | {$past(events)}) == {events})
        else $error("flag lost");
    a_slip_follows:
        assert property ($rose(events.overflow) || $rose(events.underflow)
        |-> events.slip) else $error("slip flag missing");
    c_over: cover property (events.overflow);
    c_under: cover property (events.underflow);
    c_shown: cover property (host_rvalid && host_rdata != 8'h00);
endmodule // slip_properties

bind tx_slip_buffer_event_status slip_properties slip_properties_inst (
    .clock(clock), .reset_n(reset_n), .host_req(host_req),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .events(events));

// >>> tx_slip_buffer_event_status.sv
`timescale 1ns/1ps
module tx_slip_buffer_event_status
#(
    parameter int frame_bytes = slip_pkg::frame_bytes,
    parameter int frames_held = slip_pkg::frames_held
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic bp_clock,
    input wire logic [7:0] bp_data,
    input wire logic line_clock,
    input wire slip_pkg::host_req_t host_req,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    output logic [7:0] line_data,
    output slip_pkg::slip_events_t events
);

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int depth = frame_bytes * frames_held;
    localparam int aw = $clog2(depth);
    localparam int cw = aw + 1;
    localparam logic [cw-1:0] depth_c = cw'(depth);
    localparam logic [cw-1:0] frame_c = cw'(frame_bytes);

    // advance a pointer around the ring
    function automatic logic [aw-1:0] wrap_add(input logic [aw-1:0] p,
                                                input logic [cw-1:0] n);
        logic [cw:0] s;
        s = {1'b0, {1'b0, p} + n};
        if (s >= {1'b0, depth_c})
            s = s - {1'b0, depth_c};
        return s[aw-1:0];
    endfunction

    // ------------------------------------------------------------
    // clock edge detection for both link clocks
    // ------------------------------------------------------------
    logic bp_rise;
    logic line_rise;
    logic [7:0] bp_d1_reg;
    logic [7:0] bp_d2_reg;
    logic [7:0] bp_d1_next;
    logic [7:0] bp_d2_next;

    edge_sync bp_edge
    (
        .clock(clock),
        .reset_n(reset_n),
        .async_in(bp_clock),
        .rise(bp_rise)
    );

    edge_sync line_edge
    (
        .clock(clock),
        .reset_n(reset_n),
        .async_in(line_clock),
        .rise(line_rise)
    );

    // data bus synchroniser, two stages, one cycle ahead of the registered edge pulse
    always_comb
    begin
        bp_d1_next = bp_data;
        bp_d2_next = bp_d1_reg;
    end

    // data synchroniser registers
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bp_d1_reg <= 8'h00;
            bp_d2_reg <= 8'h00;
        end
        else
        begin
            bp_d1_reg <= bp_d1_next;
            bp_d2_reg <= bp_d2_next;
        end
    end

    // ------------------------------------------------------------
    // elastic store
    // ------------------------------------------------------------
    logic [7:0] mem [depth];
    logic [aw-1:0] wptr_reg;
    logic [aw-1:0] wptr_next;
    logic [aw-1:0] rptr_reg;
    logic [aw-1:0] rptr_next;
    logic [cw-1:0] fill_reg;
    logic [cw-1:0] fill_next;
    logic [7:0] line_data_next;
    logic drop;
    logic replay;

    // pointer and fill update, slips move read by one frame
    always_comb
    begin
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        fill_next = fill_reg;
        line_data_next = line_data;
        drop = 1'b0;
        replay = 1'b0;
        if (bp_rise)
        begin
            wptr_next = wrap_add(wptr_reg, cw'(1));
            if (fill_reg == depth_c)
            begin
                drop = 1'b1;
                rptr_next = wrap_add(rptr_reg, frame_c);
                fill_next = fill_reg - frame_c + cw'(1);
            end
            else
                fill_next = fill_reg + cw'(1);
        end
        if (line_rise)
        begin
            if (fill_next == '0)
            begin
                replay = 1'b1;
                // step back one frame, then read from there
                rptr_next = wrap_add(rptr_next, depth_c - frame_c);
                fill_next = frame_c;
            end
            line_data_next = mem[rptr_next];
            // byte written on this edge is not in the array yet
            if (bp_rise && rptr_next == wptr_reg)
                line_data_next = bp_d2_reg;
            rptr_next = wrap_add(rptr_next, cw'(1));
            fill_next = fill_next - cw'(1);
        end
    end

    // storage write, no reset on the array
    always_ff @(posedge clock)
    begin
        if (bp_rise)
            mem[wptr_reg] <= bp_d2_reg;
    end

    // pointer registers
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            fill_reg <= '0;
            line_data <= 8'h00;
        end
        else
        begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            fill_reg <= fill_next;
            line_data <= line_data_next;
        end
    end

    // ------------------------------------------------------------
    // event status register
    // ------------------------------------------------------------
    slip_pkg::slip_events_t events_next;
    logic [7:0] host_rdata_next;
    logic host_rvalid_next;
    logic hit;
    logic rd_clear;

    // sticky flags, a new event beats the read clear
    always_comb
    begin
        hit = host_req.addr == slip_pkg::event_status_offset;
        rd_clear = host_req.rd & hit;
        events_next = events;
        if (rd_clear)
            events_next = '0;
        if (drop)
            events_next.overflow = 1'b1;
        if (replay)
            events_next.underflow = 1'b1;
        if (drop | replay)
            events_next.slip = 1'b1;
        host_rdata_next = 8'h00;
        host_rvalid_next = host_req.rd;
        if (rd_clear)
        begin
            host_rdata_next[slip_pkg::overflow_bit] = events.overflow;
            host_rdata_next[slip_pkg::underflow_bit] = events.underflow;
            host_rdata_next[slip_pkg::slip_bit] = events.slip;
        end
    end

    // status registers
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            events <= '0;
            host_rdata <= slip_pkg::event_status_reset;
            host_rvalid <= 1'b0;
        end
        else
        begin
            events <= events_next;
            host_rdata <= host_rdata_next;
            host_rvalid <= host_rvalid_next;
        end
    end

endmodule // tx_slip_buffer_event_status

// >>> tx_slip_buffer_event_status_bench.sv
`timescale 1ns/1ps
module tx_slip_buffer_event_status_bench;
    localparam logic [15:0] sts = slip_pkg::event_status_offset;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic line_clock = 1'b0;
    logic start = 1'b0;
    logic [7:0] burst = 8'h00;
    slip_pkg::host_req_t host_req = '0;
    logic bp_clock, busy, host_rvalid;
    logic [7:0] bp_data, host_rdata, line_data;
    slip_pkg::slip_events_t events;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    backplane_model backplane_model_inst (.clock(clock), .start(start),
        .burst(burst), .bp_clock(bp_clock), .bp_data(bp_data), .busy(busy));
    tx_slip_buffer_event_status tx_slip_buffer_event_status_inst (
        .clock(clock), .reset_n(reset_n), .bp_clock(bp_clock),
        .bp_data(bp_data), .line_clock(line_clock), .host_req(host_req),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid),
        .line_data(line_data), .events(events));
    // clock and hang guard
    initial forever #25 clock = ~clock;
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            miscompares++;
            report_and_stop;
        end
    end
    task automatic check(input string what, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic host_read(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clock);
        host_req.addr = a;
        host_req.rd = 1'b1;
        @(negedge clock);
        check("rvalid", {7'h00, host_rvalid}, 8'h01);
        check("status", host_rdata, exp);
        host_req.rd = 1'b0;
    endtask
    task automatic line_read(input int n);
        repeat (n)
        begin
            line_clock = 1'b1;
            repeat (4) @(negedge clock);
            line_clock = 1'b0;
            repeat (4) @(negedge clock);
        end
    endtask
    task automatic test_reset_write;
        @(negedge clock);
        host_req.addr = sts;
        host_req.wdata = 8'hff;
        host_req.wr = 1'b1;
        @(negedge clock);
        host_req.wr = 1'b0;
        host_read(sts, 8'h00);
    endtask
    task automatic test_overflow;
        @(negedge clock);
        burst = 8'd65;
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        while (busy) @(negedge clock);
        host_read(sts + 16'h0001, 8'h00);
        host_read(sts, 8'ha0);
        host_read(sts, 8'h00);
        line_read(1);
        check("first byte", line_data, 8'h20);
    endtask
    task automatic test_underflow;
        line_read(32);
        check("last byte", line_data, 8'h40);
        check("events", {5'h00, events}, 8'h00);
        line_read(1);
        check("replayed byte", line_data, 8'h21);
        host_read(sts, 8'h60);
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (16) @(negedge clock);
        reset_n = 1'b1;
        test_reset_write;
        test_overflow;
        test_underflow;
        report_and_stop;
    end
endmodule // tx_slip_buffer_event_status_bench
